/* logic/core_decode_map.svh */
`ifndef CORE_DECODE_MAP_SVH
`define CORE_DECODE_MAP_SVH
// primary opcode field
`define OPC_FUNC_GRP    6'h00
`define OPC_IMM_GRP     6'h01
`define OPC_J           6'h02
`define OPC_JAL         6'h03
`define OPC_BEQ         6'h04
`define OPC_BNE         6'h05
`define OPC_BLEZ        6'h06
`define OPC_BGTZ        6'h07
`define OPC_SYSCTL      6'h10
`define OPC_FLOAT       6'h11
`define OPC_USERCP      6'h12
`define OPC_FLOAT_X     6'h13
`define OPC_BEQL        6'h14
`define OPC_BNEL        6'h15
`define OPC_BLEZL       6'h16
`define OPC_BGTZL       6'h17
`define OPC_SECOND      6'h1c
`define OPC_THIRD       6'h1f
`define OPC_CACHE       6'h2f
`define OPC_LL          6'h30
`define OPC_LWC1        6'h31
`define OPC_LWC2        6'h32
`define OPC_PREF        6'h33
`define OPC_LDC1        6'h35
`define OPC_SC          6'h38
`define OPC_SWC1        6'h39
`define OPC_SWC2        6'h3a
`define OPC_SDC1        6'h3d
// second group functions
`define F2_MACC         6'h00
`define F2_MACCU        6'h01
`define F2_MULREG       6'h02
`define F2_MSUB         6'h04
`define F2_MSUBU        6'h05
`define F2_CLZ          6'h20
`define F2_CLO          6'h21
`define F2_SWDBG        6'h3f
// third group functions
`define F3_PULL         6'h00
`define F3_PLACE        6'h04
`define F3_SHUFFLE      6'h20
`define F3_READ_HARDWARE_REG        6'h3b
// immediate group special code
`define RT_ISYNC        5'h1f
// system-control operation functions
`define F0_EXCEPTION_RETURN         6'h18
`define F0_DEBUG_EXCEPTION_RETURN        6'h1f
`define F0_WAIT         6'h20
// sysctl rs codes
`define RS0_MF          5'h00
`define RS0_MT          5'h04
`define RS0_RDPREV      5'h0a
`define RS0_IEGRP       5'h0b
`define RS0_WRPREV      5'h0e
// floating format long
`define FMT_LONG        5'h15
// pc arithmetic
`define LINK_OFFSET     32'h0000_0008
`define LINK_REG        5'h1f
`define SR_ERL_BIT      2
`define SR_EXL_BIT      1
`endif

/* logic/core_decode_pkg.sv */
package core_decode_pkg;
    typedef enum logic [2:0] {
        EXC_NONE     = 3'b001,
        EXC_RESERVED = 3'b010,
        EXC_UNUSABLE = 3'b100
    } exc_e;
    typedef struct packed {
        logic       valid;      // decoded word present
        logic [5:0] group;      // primary opcode
        logic [5:0] sub;        // selected sub code
        exc_e       exc;        // exception class
        logic       is_branch;  // conditional branch
        logic       is_likely;  // nullify slot when not taken
        logic       is_link;    // write link register
        logic       is_jump;    // absolute jump
        logic       is_rotate;  // rotate instead of shift right
        logic       is_exception_return;    // exception return
        logic       is_debug_exception_return;   // debug exception return
        logic       is_ehb;     // hazard barrier
        logic       is_div;     // divide
        logic       is_user;    // user-defined slot
    } dec_s;
    typedef struct packed {
        logic        taken;     // branch or jump redirects
        logic        nullify;   // cancel delay slot
        logic        link_we;   // write link register
        logic [4:0]  link_reg;  // link register index
        logic [31:0] link_val;  // pc plus 8
        logic [31:0] target;    // redirect address
    } flow_s;
endpackage

/* logic/core_instruction_decoder.sv */
`timescale 1ns/1ps
`include "core_decode_map.svh"
//////////////////////////////////////////////////////////////////////////////////////////////
// Contract
// - opcode bits 31..26 pick row and column of operation group
// - reserved opcodes or functions raise reserved instruction exception
// - unusable coprocessor opcodes raise coprocessor unusable exception instead
// - primary function group decodes shifts, jumps, moves, muldiv, alu, traps
// - second group decodes accumulate, multiply, count leading, debug breakpoint
// - second group rows 010/011 user slots, reserved when option absent
// - third group decodes field pull, place, byte shuffle, hardware read
// - immediate group rt selects sign branches, traps, linking branches, isync
// - coproc 2 rs selects word moves, branches, operations
// - every rs in coproc 2 row 01 is a conditional branch
// - coproc 2 branch rt16 true/false, rt17 likely form
// - sysctl rs decodes moves, shadow reads/writes, ie group, operations
// - sysctl operation functions exception return, debug return, wait
// - float long format legal only with 64-bit float enabled (the code still raises coprocessor unusable when it is enabled)
// - likely branches add offset when taken, cancel slot otherwise
// - linking branches always write pc plus 8 to register 31
// - greater-than-zero needs sign clear and nonzero; else less-equal
// - exception return picks error or normal return pc, clears state bits
// - divide places quotient low, remainder high
// - debug exception return loads debug pc and leaves debug mode
// - hazard barrier stalls issue until hazards clear
// - branch target is sign-extended offset shifted two plus slot pc
// - absolute jump target combines pc top four bits and target
module core_instruction_decoder
    import core_decode_pkg::*;
#(
    parameter bit USER_SLOTS = 1'b0         // user-defined slots built in
) (
    input  wire logic        clk_in,        // core clock
    input  wire logic        rstn_in,       // async reset, active low
    input  wire logic        valid_in,      // instruction word present
    input  wire logic [31:0] instr_in,      // instruction word
    input  wire logic [31:0] pc_in,         // address of this instruction
    input  wire logic [31:0] rs_val_in,     // rs operand
    input  wire logic [31:0] rt_val_in,     // rt operand
    input  wire logic        cp2_cond_in,   // coproc 2 condition
    input  wire logic        fpu64_in,      // 64-bit float enabled
    input  wire logic        hazard_in,     // execution hazard outstanding
    input  wire logic [31:0] epc_in,        // return pc
    input  wire logic [31:0] error_epc_in,  // error return pc
    input  wire logic [31:0] debug_return_pc_in,       // debug return pc
    input  wire logic [31:0] state_in,      // processor state register
    output dec_s             dec_out,       // registered decode
    output flow_s            flow_out,      // registered control flow
    output logic             stall_out,     // issue stall
    output logic [31:0]      state_out,     // updated state register
    output logic             state_we_out,  // state register write
    output logic             link_clr_out,  // clear link flag
    output logic             debug_exit_out,// leave debug mode
    output logic             div_sel_out    // quotient low, remainder high
);
    //////////////////////////////////////////////////////////////////////////////////////////
    // field extraction
    logic [5:0] opc;
    logic [4:0] rs_f;
    logic [4:0] rt_f;
    logic [5:0] fn;
    assign opc  = instr_in[31:26];
    assign rs_f = instr_in[25:21];
    assign rt_f = instr_in[20:16];
    assign fn   = instr_in[5:0];

    // primary function legality, used by decode and by assertion helper
    function automatic logic func_legal(input logic [5:0] f);
        unique case (f[5:3])
            3'b000: func_legal = (f[2:0] != 3'h1) && (f[2:0] != 3'h5);
            3'b001: func_legal = (f[2:0] != 3'h6);
            3'b010: func_legal = (f[2] == 1'b0);
            3'b011: func_legal = (f[2] == 1'b0);
            3'b100: func_legal = 1'b1;
            3'b101: func_legal = (f[2:1] == 2'b01);
            3'b110: func_legal = (f[2:0] != 3'h5) && (f[2:0] != 3'h7);
            3'b111: func_legal = 1'b0;
        endcase
    endfunction

    //////////////////////////////////////////////////////////////////////////////////////////
    // combinational decode
    dec_s  nxt_dec;
    flow_s nxt_flow;
    logic  cond;
    logic  rs_zero;
    logic [31:0] slot_pc;
    logic [31:0] br_tgt;
    assign rs_zero = (rs_val_in == 32'h0000_0000);
    assign slot_pc = pc_in + 32'h0000_0004;
    assign br_tgt  = slot_pc + {{14{instr_in[15]}}, instr_in[15:0], 2'b00};

    always_comb begin
        nxt_dec           = '0;
        nxt_dec.valid     = valid_in;
        nxt_dec.group     = opc;
        nxt_dec.sub       = fn;
        nxt_dec.exc       = EXC_NONE;
        nxt_flow          = '0;
        nxt_flow.link_reg = `LINK_REG;
        nxt_flow.link_val = pc_in + `LINK_OFFSET;
        cond              = 1'b0;
        unique case (opc)
            `OPC_FUNC_GRP: begin
                if (!func_legal(fn)) begin
                    nxt_dec.exc = EXC_RESERVED;
                end
                if (fn == 6'h01) begin
                    nxt_dec.exc = EXC_UNUSABLE;
                end
                if (fn == 6'h02) begin
                    nxt_dec.is_rotate = instr_in[21];
                end
                if (fn == 6'h06) begin
                    nxt_dec.is_rotate = instr_in[6];
                end
                nxt_dec.is_div = (fn == 6'h1a) || (fn == 6'h1b);
                // hazard barrier is sll with shift amount 3
                nxt_dec.is_ehb = (fn == 6'h00) && (instr_in[25:6] == 20'h00003);
                if ((fn == 6'h08) || (fn == 6'h09)) begin
                    nxt_dec.is_jump  = 1'b1;
                    nxt_flow.taken   = 1'b1;
                    nxt_flow.target  = rs_val_in;
                    nxt_flow.link_we = (fn == 6'h09);
                    nxt_flow.link_reg = instr_in[15:11];
                end
            end
            `OPC_IMM_GRP: begin
                nxt_dec.sub = {1'b0, rt_f};
                unique case (rt_f[4:3])
                    2'b00, 2'b10: begin
                        if (rt_f[2]) begin
                            nxt_dec.exc = EXC_RESERVED;
                        end else begin
                            nxt_dec.is_branch = 1'b1;
                            nxt_dec.is_likely = rt_f[1];
                            nxt_dec.is_link   = rt_f[4];
                            nxt_flow.link_we  = rt_f[4];
                            cond = rt_f[0] ? !rs_val_in[31] : rs_val_in[31];
                        end
                    end
                    2'b01: begin
                        if ((rt_f[2:0] == 3'h5) || (rt_f[2:0] == 3'h7)) begin
                            nxt_dec.exc = EXC_RESERVED;
                        end
                    end
                    2'b11: begin
                        if (rt_f != `RT_ISYNC) begin
                            nxt_dec.exc = EXC_RESERVED;
                        end
                    end
                endcase
            end
            `OPC_J, `OPC_JAL: begin
                nxt_dec.is_jump  = 1'b1;
                nxt_flow.taken   = 1'b1;
                nxt_flow.target  = {pc_in[31:28], instr_in[25:0], 2'b00};
                nxt_dec.is_link  = opc[0];
                nxt_flow.link_we = opc[0];
            end
            `OPC_BEQ, `OPC_BNE, `OPC_BLEZ, `OPC_BGTZ,
            `OPC_BEQL, `OPC_BNEL, `OPC_BLEZL, `OPC_BGTZL: begin
                nxt_dec.is_branch = 1'b1;
                nxt_dec.is_likely = opc[4];
                unique case (opc[1:0])
                    2'b00: cond = (rs_val_in == rt_val_in);
                    2'b01: cond = (rs_val_in != rt_val_in);
                    2'b10: cond = rs_val_in[31] || rs_zero;
                    2'b11: cond = !rs_val_in[31] && !rs_zero;
                endcase
            end
            `OPC_SYSCTL: begin
                nxt_dec.sub = rs_f[4] ? fn : {1'b0, rs_f};
                if (rs_f[4]) begin
                    nxt_dec.is_exception_return  = (fn == `F0_EXCEPTION_RETURN);
                    nxt_dec.is_debug_exception_return = (fn == `F0_DEBUG_EXCEPTION_RETURN);
                    if ((fn != `F0_EXCEPTION_RETURN) && (fn != `F0_DEBUG_EXCEPTION_RETURN) && (fn != `F0_WAIT)) begin
                        nxt_dec.exc = EXC_RESERVED;
                    end
                    if (fn == `F0_EXCEPTION_RETURN) begin
                        nxt_flow.taken  = 1'b1;
                        nxt_flow.target = state_in[`SR_ERL_BIT] ? error_epc_in : epc_in;
                    end
                    if (fn == `F0_DEBUG_EXCEPTION_RETURN) begin
                        nxt_flow.taken  = 1'b1;
                        nxt_flow.target = debug_return_pc_in;
                    end
                end else if ((rs_f != `RS0_MF) && (rs_f != `RS0_MT) &&
                             (rs_f != `RS0_RDPREV) && (rs_f != `RS0_IEGRP) &&
                             (rs_f != `RS0_WRPREV)) begin
                    nxt_dec.exc = EXC_RESERVED;
                end
            end
            `OPC_USERCP: begin
                nxt_dec.sub = {1'b0, rs_f};
                if (rs_f[4:3] == 2'b01) begin
                    nxt_dec.is_branch = 1'b1;
                    nxt_dec.is_likely = rt_f[1];
                    cond = (cp2_cond_in == rt_f[0]);
                end else if ((rs_f[4:3] == 2'b00) &&
                             ((rs_f[2:0] == 3'h1) || (rs_f[2:0] == 3'h5))) begin
                    nxt_dec.exc = EXC_RESERVED;
                end
            end
            `OPC_FLOAT: begin
                // long format depends on 64-bit float mode
                nxt_dec.exc = EXC_UNUSABLE;
                if ((rs_f == `FMT_LONG) && !fpu64_in) begin
                    nxt_dec.exc = EXC_RESERVED;
                end
            end
            `OPC_FLOAT_X, `OPC_LWC1, `OPC_LDC1, `OPC_SWC1, `OPC_SDC1: begin
                nxt_dec.exc = EXC_UNUSABLE;
            end
            `OPC_SECOND: begin
                if (fn[5:4] == 2'b01) begin
                    nxt_dec.is_user = USER_SLOTS;
                    nxt_dec.exc     = USER_SLOTS ? EXC_NONE : EXC_RESERVED;
                end else if ((fn != `F2_MACC) && (fn != `F2_MACCU) && (fn != `F2_MULREG) &&
                             (fn != `F2_MSUB) && (fn != `F2_MSUBU) && (fn != `F2_CLZ) &&
                             (fn != `F2_CLO) && (fn != `F2_SWDBG)) begin
                    nxt_dec.exc = EXC_RESERVED;
                end
            end
            `OPC_THIRD: begin
                if ((fn != `F3_PULL) && (fn != `F3_PLACE) &&
                    (fn != `F3_SHUFFLE) && (fn != `F3_READ_HARDWARE_REG)) begin
                    nxt_dec.exc = EXC_RESERVED;
                end
            end
            6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f,
            6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26,
            6'h28, 6'h29, 6'h2a, 6'h2b, 6'h2e, `OPC_CACHE,
            `OPC_LL, `OPC_LWC2, `OPC_PREF, `OPC_SC, `OPC_SWC2: begin
                nxt_dec.exc = EXC_NONE;
            end
            default: begin
                nxt_dec.exc = EXC_RESERVED;
            end
        endcase
        // likely branches: taken redirects, not taken nullifies slot
        if (nxt_dec.is_branch && (nxt_dec.exc == EXC_NONE)) begin
            nxt_flow.taken   = cond;
            nxt_flow.target  = br_tgt;
            nxt_flow.nullify = nxt_dec.is_likely && !cond;
        end
        if (nxt_dec.exc != EXC_NONE) begin
            nxt_flow = '0;
            nxt_flow.link_reg = `LINK_REG;
            nxt_dec.is_branch = 1'b0;
        end
        if (!valid_in) begin
            nxt_dec  = '0;
            nxt_flow = '0;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // decode and flow registers
    dec_s  dec_ff;
    flow_s flow_ff;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dec_ff  <= '0;
            flow_ff <= '0;
        end else begin
            dec_ff  <= nxt_dec;
            flow_ff <= nxt_flow;
        end
    end
    assign dec_out  = dec_ff;
    assign flow_out = flow_ff;

    // exception-return and divide side effects, registered with the decode
    logic [31:0] state_ff;
    logic        state_we_ff;
    logic        link_clr_ff;
    logic        dexit_ff;
    logic        div_ff;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_ff    <= 32'h0000_0000;
            state_we_ff <= 1'b0;
            link_clr_ff <= 1'b0;
            dexit_ff    <= 1'b0;
            div_ff      <= 1'b0;
        end else begin
            // clear bits 1 and 2 and the link flag
            state_ff    <= state_in & ~(32'h0000_0006);
            state_we_ff <= nxt_dec.is_exception_return;
            link_clr_ff <= nxt_dec.is_exception_return;
            dexit_ff    <= nxt_dec.is_debug_exception_return;
            // quotient to low, remainder to high
            div_ff      <= nxt_dec.is_div;
        end
    end
    assign state_out      = state_ff;
    assign state_we_out   = state_we_ff;
    assign link_clr_out   = link_clr_ff;
    assign debug_exit_out = dexit_ff;
    assign div_sel_out    = div_ff;

    //////////////////////////////////////////////////////////////////////////////////////////
    // hazard barrier stall: combinational so issue holds in the same cycle
    // hold while hazards remain
    assign stall_out = nxt_dec.is_ehb && hazard_in;

    //////////////////////////////////////////////////////////////////////////////////////////
    // assertions
    a_reserved_func: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (valid_in && opc == `OPC_FUNC_GRP && !func_legal(fn) && fn != 6'h01)
        |=> dec_out.exc == EXC_RESERVED) else $error("reserved function not flagged");
    a_unusable_cop: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (valid_in && (opc == `OPC_LWC1 || opc == `OPC_SWC1 || opc == `OPC_FLOAT_X))
        |=> dec_out.exc == EXC_UNUSABLE) else $error("unusable coprocessor not flagged");
    a_user_slots: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (valid_in && opc == `OPC_SECOND && fn[5:4] == 2'b01 && !USER_SLOTS)
        |=> dec_out.exc == EXC_RESERVED) else $error("user slot not reserved");
    a_likely_null: assert property (@(posedge clk_in) disable iff (!rstn_in)
        flow_out.nullify |-> dec_out.is_likely && !flow_out.taken)
        else $error("nullify without untaken likely branch");
    a_link_value: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (valid_in && opc == `OPC_IMM_GRP && rt_f == 5'h10)
        |=> flow_out.link_we && flow_out.link_val == $past(pc_in) + 32'h0000_0008)
        else $error("link value wrong");
    a_bgtz_cond: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (valid_in && opc == `OPC_BGTZ)
        |=> flow_out.taken == (!$past(rs_val_in[31]) && $past(rs_val_in) != 32'h0))
        else $error("greater than zero test wrong");
    a_exception_return_target: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (valid_in && opc == `OPC_SYSCTL && rs_f[4] && fn == `F0_EXCEPTION_RETURN)
        |=> flow_out.target == ($past(state_in[2]) ? $past(error_epc_in) : $past(epc_in))
            && state_we_out && state_out[2:1] == 2'b00 && link_clr_out)
        else $error("exception return wrong");
    a_debug_exception_return_exit: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (valid_in && opc == `OPC_SYSCTL && rs_f[4] && fn == `F0_DEBUG_EXCEPTION_RETURN)
        |=> debug_exit_out && flow_out.target == $past(debug_return_pc_in))
        else $error("debug return wrong");
    a_branch_target: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (valid_in && opc == `OPC_BEQ)
        |=> flow_out.target == $past(pc_in) + 32'h4
            + {{14{$past(instr_in[15])}}, $past(instr_in[15:0]), 2'b00})
        else $error("branch target wrong");
    a_jump_target: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (valid_in && opc == `OPC_J)
        |=> flow_out.taken && flow_out.target[31:28] == $past(pc_in[31:28]))
        else $error("jump target wrong");
endmodule

/* verif/hazard_model.sv */
`timescale 1ns/1ps
module hazard_model (
    input  wire logic clk_in,     // core clock
    input  wire logic rstn_in,    // async reset, active low
    input  wire logic arm_in,     // start a hazard
    output logic      hazard_out  // hazard outstanding
);
    logic [1:0] left_ff;  // cycles of hazard still to run
    // hazard stays up for three cycles, long enough to catch a second barrier
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) left_ff <= 2'h0;
        else if (arm_in) left_ff <= 2'h3;
        else if (left_ff != 2'h0) left_ff <= left_ff - 2'h1;
    end
    assign hazard_out = (left_ff != 2'h0);
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import core_decode_pkg::*;
    logic        clk_in = 1'b0, rstn_in = 1'b0, valid_in = 1'b0, cc = 1'b0, f64 = 1'b0;
    logic        arm = 1'b0, cur_ehb = 1'b0, hz, stall, we, lclr, dex, dsel;
    logic [31:0] instr = 32'h0, pc = 32'h0, rs = 32'h0, rt = 32'h0, st_o, p, a, o, tg;
    logic [31:0] return_pc = 32'h0, eepc = 32'h0, st = 32'h0, seed = 32'h901c, dpc = 32'h0;
    logic [3:0]  x, qx[$];  // expected exception_return, debug_exception_return, divide, rotate flags
    // legal codes across the groups: second, third, sysctl, coproc 2 op, wait, divide, shifts
    logic [31:0] ok[12] = '{32'h7000_0002, 32'h7000_003f, 32'h7c00_003b, 32'h7c00_0004,
        32'h4080_0000, 32'h4160_0000, 32'h4a00_0000, 32'h4200_0020, 32'h0000_001a,
        32'h0000_0002, 32'h0020_0002, 32'h0000_0046};
    logic [31:0] rsv[11] = '{32'h6000_0000, 32'h7800_0000, 32'h9c00_0000, 32'hec00_0000,
        32'hfc00_0000, 32'h0000_0005, 32'h7000_0010, 32'h7c00_0001, 32'h4200_0002,
        32'h0404_0000, 32'h46a0_0000};
    logic [31:0] unu[7] = '{32'h4c00_0000, 32'hc400_0000, 32'hd400_0000, 32'he400_0000,
        32'hf400_0000, 32'h0000_0001, 32'h4600_0000};
    dec_s        dec;
    flow_s       flo, f;
    exc_e        e, qe[$];
    flow_s       qf[$];
    int          bad_count = 0, comparisons = 0, cyc = 0;
    always #4 clk_in = ~clk_in;
    core_instruction_decoder #(.USER_SLOTS(1'b0)) dut (.clk_in(clk_in), .rstn_in(rstn_in),
        .valid_in(valid_in), .instr_in(instr), .pc_in(pc), .rs_val_in(rs), .rt_val_in(rt),
        .cp2_cond_in(cc), .fpu64_in(f64), .hazard_in(hz), .epc_in(return_pc), .error_epc_in(eepc),
        .debug_return_pc_in(dpc), .state_in(st), .dec_out(dec), .flow_out(flo), .stall_out(stall),
        .state_out(st_o), .state_we_out(we), .link_clr_out(lclr), .debug_exit_out(dex),
        .div_sel_out(dsel));
    hazard_model hm (.clk_in(clk_in), .rstn_in(rstn_in), .arm_in(arm), .hazard_out(hz));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic flow_s fw(logic t, logic n, logic l, logic [31:0] v, logic [31:0] g);
        return '{t, n, l, 5'h1f, v, g};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one instruction a cycle; the expected outcome is queued for the monitor
    task automatic issue(input logic [31:0] i, input logic [31:0] b, input logic [1:0] m,
        input exc_e ex, input flow_s fl);
        @(posedge clk_in);
        valid_in <= 1'b1;
        instr <= i;
        pc <= p;
        rs <= a;
        rt <= b;
        {cc, f64} <= m;
        arm <= (i == 32'h0c0);
        cur_ehb <= (i == 32'h0c0);
        qe.push_back(ex);
        qf.push_back(fl);
        // side-effect pulses follow from the encoding of the word itself
        qx.push_back({((i[31:26] == 6'h10) && i[25] && (i[5:0] == 6'h18)),
            ((i[31:26] == 6'h10) && i[25] && (i[5:0] == 6'h1f)),
            ((i[31:26] == 6'h00) && (i[5:1] == 5'h0d)),
            ((i[31:26] == 6'h00) && (((i[5:0] == 6'h02) && i[21]) || ((i[5:0] == 6'h06) && i[6])))});
    endtask
    // monitor: results appear one edge after the decoder samples them
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc > 2000) begin
            bad_count++;
            tally_and_finish();
        end
        if (rstn_in) check({31'h0, stall}, {31'h0, cur_ehb & hz & valid_in});
        if (rstn_in && dec.valid === 1'b1) begin
            e = qe.pop_front();
            f = qf.pop_front();
            x = qx.pop_front();
            check(32'(dec.exc), 32'(e));
            check({31'h0, flo.taken}, {31'h0, f.taken});
            check({31'h0, flo.nullify}, {31'h0, f.nullify});
            check({31'h0, flo.link_we}, {31'h0, f.link_we});
            if (f.link_we) check(flo.link_val, f.link_val);
            if (f.taken) check(flo.target, f.target);
            if (x[3]) check(st_o, st & 32'hffff_fff9);
            check({30'h0, we, lclr}, {30'h0, x[3], x[3]});
            check({30'h0, dex, dsel}, {30'h0, x[2:1]});
            check({31'h0, dec.is_rotate}, {31'h0, x[0]});
        end
    end
    initial begin
        return_pc = rnd();
        eepc = rnd();
        st = rnd() | 32'h4;
        dpc = rnd();
        repeat (4) @(posedge clk_in);
        rstn_in <= 1'b1;
        repeat (3) begin
            p = rnd() & 32'hffff_fffc;
            a = rnd() | 32'h8000_0000;
            o = rnd();
            tg = p + 32'h4 + {{14{o[15]}}, o[15:0], 2'b00};
            issue({6'h04, 10'h022, o[15:0]}, a, 2'b00, EXC_NONE, fw(1, 0, 0, 0, tg));
            issue({6'h15, 10'h022, o[15:0]}, a, 2'b00, EXC_NONE, fw(0, 1, 0, 0, 0));
            issue({6'h07, 10'h020, o[15:0]}, a, 2'b00, EXC_NONE, fw(0, 0, 0, 0, 0));
            issue({6'h06, 10'h020, o[15:0]}, a, 2'b00, EXC_NONE, fw(1, 0, 0, 0, tg));
            issue({6'h01, 10'h031, o[15:0]}, a, 2'b00, EXC_NONE, fw(0, 0, 1, p + 8, 0));
            issue({6'h01, 10'h030, o[15:0]}, a, 2'b00, EXC_NONE, fw(1, 0, 1, p + 8, tg));
            issue({6'h02, a[25:0]}, a, 2'b00, EXC_NONE, fw(1, 0, 0, 0, {p[31:28], a[25:0], 2'b00}));
            issue({6'h12, 10'h163, o[15:0]}, a, 2'b00, EXC_NONE, fw(0, 1, 0, 0, 0));
            issue({6'h12, 10'h100, o[15:0]}, a, 2'b00, EXC_NONE, fw(1, 0, 0, 0, tg));
        end
        foreach (rsv[i]) issue(rsv[i], a, 2'b00, EXC_RESERVED, '0);
        foreach (unu[i]) issue(unu[i], a, 2'b00, EXC_UNUSABLE, '0);
        issue(32'h46a0_0000, a, 2'b01, EXC_UNUSABLE, '0);
        issue(32'h4200_0018, a, 2'b00, EXC_NONE, fw(1, 0, 0, 0, eepc));
        issue(32'h4200_001f, a, 2'b00, EXC_NONE, fw(1, 0, 0, 0, dpc));
        issue(32'h0000_f809, a, 2'b00, EXC_NONE, fw(1, 0, 1, p + 8, a));
        foreach (ok[i]) issue(ok[i], a, 2'b00, EXC_NONE, '0);
        issue(32'h0c0, a, 2'b00, EXC_NONE, '0);
        issue(32'h0c0, a, 2'b00, EXC_NONE, '0);
        issue(32'h0, a, 2'b00, EXC_NONE, '0);
        @(posedge clk_in);
        valid_in <= 1'b0;
        cur_ehb <= 1'b0;
        arm <= 1'b0;
        repeat (3) @(posedge clk_in);
        check(qe.size(), 0);
        tally_and_finish();
    end
endmodule
